/* File: hbs_device.sv */
// Design decisions made here: the placing of the registers and the strobed register port.
`timescale 1ns/1ps
`include "hbs_map.svh"
module hbs_device (
	input  wire logic       clk_sys,
	input  wire logic       nrst,
	hbs_link_if.device      link,
	input  wire logic       overvoltage,
	input  wire logic       undervoltage_lockout,
	input  wire logic [5:0] overcurrent,
	input  wire logic [5:0] underload,
	input  wire logic       thermal_warm,
	output logic      [5:0] drive_on,
	output logic            overvoltage_lockout_enable,
	output logic            overcurrent_shutdown_enable
);
	logic [2:0] pins_s;
	logic       csn_s, sck_s, sdi_s;
	// select idles high: a zero reset value would fake a select fall at release
	hbs_sync #(.W(3), .RST(3'h4)) u_sync (
		.clk_sys  (clk_sys),
		.nrst     (nrst),
		.async_in ({link.chip_select_n, link.sclk, link.sdi}),
		.sync_out (pins_s)
	);
	assign {csn_s, sck_s, sdi_s} = pins_s;

	// fault detectors are levels from outside this clock domain
	logic [14:0] flt_s;
	logic        ov_s, undervoltage_lockout_s, warm_s;
	logic [5:0]  oc_s, ul_s;
	hbs_sync #(.W(15), .RST(15'h0000)) u_sync_flt (
		.clk_sys  (clk_sys),
		.nrst     (nrst),
		.async_in ({overvoltage, undervoltage_lockout, overcurrent, underload, thermal_warm}),
		.sync_out (flt_s)
	);
	assign {ov_s, undervoltage_lockout_s, oc_s, ul_s, warm_s} = flt_s;

	logic [15:0] shift_q, shift_d;
	logic [15:0] txsh_q, txsh_d;
	logic [3:0]  cnt_q, cnt_d;
	logic        csn_q, sck_q;
	logic        any_q, any_d;
	logic [5:0]  prog_q, prog_d;
	logic [5:0]  latchoff_q, latchoff_d;
	logic        overvoltage_lockout_enable_q, overvoltage_lockout_enable_d, ocd_q, ocd_d;
	logic        psf_q, psf_d, uld_q, uld_d, old_q, old_d, tw_q, tw_d;
	logic [15:0] filt_q, filt_d;
	logic        sdo_q, sdo_d, oen_q, oen_d;
	logic [5:0]  drv_q, drv_d;

	function automatic logic [15:0] status_word(input logic [5:0] st, input logic p,
		input logic u, input logic o, input logic t);
		logic [15:0] w;
		w = 16'h0000;
		w[`HBS_BIT_SUPPLY]    = p;
		w[`HBS_BIT_UNDERLOAD] = u;
		w[`HBS_BIT_OVERLOAD]  = o;
		w[`HBS_BIT_DRV_HI:`HBS_BIT_DRV_LO] = st;
		w[`HBS_BIT_THERMAL]   = t;
		return w;
	endfunction

	always_comb begin
		logic cs_fall, cs_rise, rise, fall, valid, filt_ok;
		cs_fall = csn_q && !csn_s;
		cs_rise = !csn_q && csn_s;
		rise = !csn_s && sck_s && !sck_q;
		fall = !csn_s && !sck_s && sck_q;
		// a frame with no clock at all must not apply the stale shift register again
		valid = cs_rise && any_q && (cnt_q == 4'h0) && !sck_s;
		filt_ok = (filt_q == 16'h0000);
		shift_d = shift_q;
		txsh_d = txsh_q;
		cnt_d = cnt_q;
		any_d = any_q;
		sdo_d = sdo_q;
		oen_d = csn_s;
		prog_d = prog_q;
		overvoltage_lockout_enable_d = overvoltage_lockout_enable_q;
		ocd_d = ocd_q;
		latchoff_d = latchoff_q;
		psf_d = psf_q;
		uld_d = uld_q;
		old_d = old_q;
		tw_d = tw_q;
		filt_d = filt_ok ? filt_q : filt_q - 16'h0001;
		if (cs_fall) begin
			cnt_d = 4'h0;
			any_d = 1'b0;
			txsh_d = status_word(drv_q, psf_q, uld_q, old_q, tw_q);
			sdo_d = txsh_d[0];
		end
		if (fall) begin
			shift_d = {sdi_s, shift_q[15:1]};
			// the bit sampled here leaves on sdo fifteen clock rises later, for chaining
			txsh_d[15] = sdi_s;
		end
		if (rise) begin
			cnt_d = cnt_q + 4'h1;
			any_d = 1'b1;
			txsh_d = {1'b0, txsh_q[15:1]};
			sdo_d = txsh_q[1];
		end
		if (valid) begin
			overvoltage_lockout_enable_d = shift_q[`HBS_BIT_OVERVOLTAGE_LOCKOUT_ENABLE_EN];
			ocd_d = shift_q[`HBS_BIT_OCD_EN];
			prog_d = shift_q[`HBS_BIT_DRV_HI:`HBS_BIT_DRV_LO];
			psf_d = 1'b0;
			uld_d = 1'b0;
			old_d = 1'b0;
			filt_d = 16'(`HBS_FILTER_CYC);
			if (shift_q[`HBS_BIT_SRR]) begin
				tw_d = 1'b0;
				latchoff_d = 6'h00;
			end
		end else if (filt_ok) begin
			// set beats any clear that is not a valid frame
			if (ov_s || undervoltage_lockout_s)
				psf_d = 1'b1;
			if (|(ul_s & drv_q))
				uld_d = 1'b1;
			if (|(oc_s & drv_q))
				old_d = 1'b1;
			if (ocd_q)
				latchoff_d = latchoff_q | (oc_s & drv_q);
			if (warm_s)
				tw_d = 1'b1;
		end
		drv_d = (overvoltage_lockout_enable_q && ov_s) || undervoltage_lockout_s ? 6'h00
			: prog_q & ~latchoff_q;
	end

	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			shift_q <= 16'h0000;
			txsh_q <= 16'h0000;
			cnt_q <= 4'h0;
			any_q <= 1'b0;
			csn_q <= 1'b1;
			sck_q <= 1'b0;
			prog_q <= 6'h00;
			latchoff_q <= 6'h00;
			overvoltage_lockout_enable_q <= 1'b0;
			ocd_q <= 1'b0;
			psf_q <= 1'b0;
			uld_q <= 1'b0;
			old_q <= 1'b0;
			tw_q <= 1'b0;
			filt_q <= 16'h0000;
			sdo_q <= 1'b0;
			oen_q <= 1'b1;
			drv_q <= 6'h00;
		end else begin
			shift_q <= shift_d;
			txsh_q <= txsh_d;
			cnt_q <= cnt_d;
			any_q <= any_d;
			csn_q <= csn_s;
			sck_q <= sck_s;
			prog_q <= prog_d;
			latchoff_q <= latchoff_d;
			overvoltage_lockout_enable_q <= overvoltage_lockout_enable_d;
			ocd_q <= ocd_d;
			psf_q <= psf_d;
			uld_q <= uld_d;
			old_q <= old_d;
			tw_q <= tw_d;
			filt_q <= filt_d;
			sdo_q <= sdo_d;
			oen_q <= oen_d;
			drv_q <= drv_d;
		end
	end

	assign link.sdo = sdo_q;
	assign link.sdo_oe_n = oen_q;
	assign drive_on = drv_q;
	assign overvoltage_lockout_enable = overvoltage_lockout_enable_q;
	assign overcurrent_shutdown_enable = ocd_q;
endmodule

/* File: hbs_map.svh */
`ifndef HBS_MAP_SVH
`define HBS_MAP_SVH
`define HBS_WORD_BITS      16
`define HBS_BIT_OVERVOLTAGE_LOCKOUT_ENABLE_EN    15
`define HBS_BIT_OCD_EN     13
`define HBS_BIT_SUPPLY     15
`define HBS_BIT_UNDERLOAD  14
`define HBS_BIT_OVERLOAD   13
`define HBS_BIT_DRV_HI     6
`define HBS_BIT_DRV_LO     1
`define HBS_BIT_SRR        0
`define HBS_BIT_THERMAL    0
`define HBS_FILTER_NS      1000
`define HBS_CLK_NS         100
`define HBS_FILTER_CYC     ((`HBS_FILTER_NS + `HBS_CLK_NS - 1) / `HBS_CLK_NS)
`define HBS_HALF_DIV       4
`define HBS_CMD_WRITE      16'h0000
`define HBS_CMD_READ_RX    16'h0004
`define HBS_CMD_READ_STAT  16'h0008
`define HBS_CMD_FRAMES     16'h000C
`endif

/* File: hbs_pkg.sv */
package hbs_pkg;
	typedef logic [15:0] hbs_word_t;
	typedef enum logic [1:0] {HBS_IDLE, HBS_LOW, HBS_HIGH, HBS_END} hbs_state_t;
endpackage

/* File: hbs_link_if.sv */
`timescale 1ns/1ps
interface hbs_link_if;
	logic chip_select_n;
	logic sclk;
	logic sdi;
	logic sdo;
	logic sdo_oe_n;
	logic sdo_wire;
	// released pin has no pull: show the inverse so an off-frame sample is caught
	assign sdo_wire = sdo_oe_n ? ~sdo : sdo;
	modport device (input chip_select_n, input sclk, input sdi, output sdo, output sdo_oe_n);
	modport host (output chip_select_n, output sclk, output sdi, input sdo_wire);
endinterface

/* File: hbs_sync.sv */
`timescale 1ns/1ps
module hbs_sync #(
	parameter int           W   = 3,
	parameter logic [W-1:0] RST = '0
) (
	input  wire logic         clk_sys,
	input  wire logic         nrst,
	input  wire logic [W-1:0] async_in,
	output logic      [W-1:0] sync_out
);
	logic [W-1:0] meta_q;
	logic [W-1:0] sync_q;
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			// reset to RST, the pins' idle level where the instance sets it (the device's pin sync), so no edge appears there at release
			meta_q <= RST;
			sync_q <= RST;
		end else begin
			meta_q <= async_in;
			sync_q <= meta_q;
		end
	end
	assign sync_out = sync_q;
endmodule

/* File: hbs_host.sv */
`timescale 1ns/1ps
`include "hbs_map.svh"
module hbs_host #(
	parameter int HALF_DIV = `HBS_HALF_DIV
) (
	input  wire logic        clk_sys,
	input  wire logic        nrst,
	hbs_link_if.host         link,
	input  wire logic [15:0] addr,
	input  wire logic [15:0] wdata,
	input  wire logic        wr,
	input  wire logic        rd,
	output logic      [15:0] rdata
);
	logic sdo_s;
	hbs_sync #(.W(1)) u_sync (
		.clk_sys  (clk_sys),
		.nrst     (nrst),
		.async_in (link.sdo_wire),
		.sync_out (sdo_s)
	);

	hbs_pkg::hbs_state_t st_q, st_d;
	logic [15:0] tx_q, tx_d, rx_q, rx_d, rd_q, rd_d, frames_q, frames_d;
	logic [7:0]  div_q, div_d;
	logic [4:0]  bit_q, bit_d;
	logic        csn_q, csn_d, sck_q, sck_d, sdi_q, sdi_d;

	// sdi changes with each clock rise so it stands still at the device's fall sample;
	// sdo is taken at the fall, which through both synchronisers still shows the old bit
	always_comb begin
		logic tick;
		tick = (div_q == 8'(HALF_DIV - 1));
		st_d = st_q;
		tx_d = tx_q;
		rx_d = rx_q;
		frames_d = frames_q;
		bit_d = bit_q;
		csn_d = csn_q;
		sck_d = sck_q;
		sdi_d = sdi_q;
		div_d = tick ? 8'h00 : div_q + 8'h01;
		rd_d = 16'h0000;
		if (rd) begin
			case (addr)
				`HBS_CMD_READ_RX:   rd_d = rx_q;
				`HBS_CMD_READ_STAT: rd_d = {15'h0000, st_q != hbs_pkg::HBS_IDLE};
				`HBS_CMD_FRAMES:    rd_d = frames_q;
				default:            rd_d = 16'h0000;
			endcase
		end
		case (st_q)
			hbs_pkg::HBS_IDLE: begin
				div_d = 8'h00;
				if (wr && addr == `HBS_CMD_WRITE) begin
					tx_d = wdata;
					csn_d = 1'b0;
					sdi_d = wdata[0];
					bit_d = 5'h00;
					st_d = hbs_pkg::HBS_LOW;
				end
			end
			hbs_pkg::HBS_LOW: if (tick) begin
				sck_d = 1'b1;
				sdi_d = tx_q[0];
				tx_d = {1'b0, tx_q[15:1]};
				st_d = hbs_pkg::HBS_HIGH;
			end
			hbs_pkg::HBS_HIGH: if (tick) begin
				sck_d = 1'b0;
				rx_d = {sdo_s, rx_q[15:1]};
				bit_d = bit_q + 5'h01;
				st_d = (bit_q == 5'(`HBS_WORD_BITS - 1)) ? hbs_pkg::HBS_END
					: hbs_pkg::HBS_LOW;
			end
			hbs_pkg::HBS_END: if (tick) begin
				if (csn_q) begin
					st_d = hbs_pkg::HBS_IDLE;
				end else begin
					csn_d = 1'b1;
					frames_d = frames_q + 16'h0001;
				end
			end
			default: st_d = hbs_pkg::HBS_IDLE;
		endcase
	end

	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			st_q <= hbs_pkg::HBS_IDLE;
			tx_q <= 16'h0000;
			rx_q <= 16'h0000;
			rd_q <= 16'h0000;
			frames_q <= 16'h0000;
			div_q <= 8'h00;
			bit_q <= 5'h00;
			csn_q <= 1'b1;
			sck_q <= 1'b0;
			sdi_q <= 1'b0;
		end else begin
			st_q <= st_d;
			tx_q <= tx_d;
			rx_q <= rx_d;
			rd_q <= rd_d;
			frames_q <= frames_d;
			div_q <= div_d;
			bit_q <= bit_d;
			csn_q <= csn_d;
			sck_q <= sck_d;
			sdi_q <= sdi_d;
		end
	end

	assign link.chip_select_n = csn_q;
	assign link.sclk = sck_q;
	assign link.sdi = sdi_q;
	assign rdata = rd_q;
endmodule

/* File: hbs_link_chk.sv */
`timescale 1ns/1ps
module hbs_link_chk (
	input wire logic clk_sys,
	input wire logic nrst,
	input wire logic chip_select_n,
	input wire logic sclk,
	input wire logic sdi,
	input wire logic sdo,
	input wire logic sdo_oe_n
);
	logic [4:0] rise_q;
	logic [4:0] rise_d;
	logic       sclk_q;
	always_comb begin
		rise_d = chip_select_n ? 5'h00 : rise_q + {4'h0, sclk & ~sclk_q};
	end
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			rise_q <= 5'h00;
			sclk_q <= 1'b0;
		end else begin
			rise_q <= rise_d;
			sclk_q <= sclk;
		end
	end
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!nrst);
	a_oe_release: assert property ($rose(chip_select_n) |-> ##[1:4] sdo_oe_n)
		else $error("serial output still driven after deselect");
	a_oe_drive: assert property ($fell(chip_select_n) |-> ##[1:4] !sdo_oe_n)
		else $error("serial output not driven in frame");
	a_oe_idle: assert property (chip_select_n [*5] |-> sdo_oe_n)
		else $error("serial output driven while idle");
	a_sclk_end_low: assert property ($rose(chip_select_n) |-> !sclk && !$past(sclk))
		else $error("clock high at deselect");
	a_sclk_idle: assert property (chip_select_n |-> !sclk)
		else $error("clock moves outside frame");
	a_word_len: assert property ($rose(chip_select_n) |-> rise_q == 5'h10)
		else $error("frame not 16 clocks");
	a_cs_gap: assert property ($rose(chip_select_n) |=> chip_select_n [*2])
		else $error("deselect gap too short");
	a_cs_setup: assert property ($fell(chip_select_n) |-> !sclk [*3])
		else $error("clock too soon after select");
	a_sdi_hold: assert property (sclk && $past(sclk) |-> $stable(sdi))
		else $error("input data moved while clock high");
	a_sdo_hold: assert property ($fell(sclk) && !chip_select_n |=> (sdo_oe_n || $stable(sdo)) [*4])
		else $error("output data moved after clock fall");
	c_frame: cover property ($rose(chip_select_n));
	c_drive: cover property ($fell(sdo_oe_n));
	c_sdo_one: cover property (!chip_select_n && sdo);
endmodule

/* File: half_bridge_spi_control_status_tb.sv */
`timescale 1ns/1ps
module half_bridge_spi_control_status_tb;
	logic        clk_sys, nrst, wr, rd, ov, uv, warm, overvoltage_lockout_enable_en, ocd_en;
	logic [15:0] addr, wdata, rdata, q;
	logic [5:0]  oc, ul, drv;
	int          error_cnt, checks, frames;
	hbs_link_if link ();
	hbs_host #(.HALF_DIV(4)) i_hbs_host (.clk_sys(clk_sys), .nrst(nrst), .link(link),
		.addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata));
	hbs_device i_hbs_device (.clk_sys(clk_sys), .nrst(nrst), .link(link), .overvoltage(ov),
		.undervoltage_lockout(uv), .overcurrent(oc), .underload(ul), .thermal_warm(warm),
		.drive_on(drv), .overvoltage_lockout_enable(overvoltage_lockout_enable_en), .overcurrent_shutdown_enable(ocd_en));
	hbs_link_chk i_hbs_link_chk (.clk_sys(clk_sys), .nrst(nrst), .chip_select_n(link.chip_select_n),
		.sclk(link.sclk), .sdi(link.sdi), .sdo(link.sdo), .sdo_oe_n(link.sdo_oe_n));
	initial begin
		clk_sys = 1'b0;
		forever #50 clk_sys = ~clk_sys;
	end
	function automatic logic [15:0] stat(input logic [5:0] d, input logic [3:0] f);
		return {f[3:1], 6'h00, d, f[0]};
	endfunction
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic br(input logic [15:0] a);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk_sys);
		rd <= 1'b0;
		#1 q = rdata;
		@(posedge clk_sys);
	endtask
	// wait on the busy flag, then let faults relatch before taking the returned word
	task automatic send(input logic [15:0] c);
		int n;
		addr <= 16'h0000;
		wdata <= c;
		wr <= 1'b1;
		@(posedge clk_sys);
		wr <= 1'b0;
		frames++;
		n = 0;
		do begin
			br(16'h0008);
			n++;
		end while (q[0] !== 1'b0 && n < 300);
		if (q[0] !== 1'b0) begin
			error_cnt++;
			$display("MISMATCH t=%0t frame never finished", $time);
		end
		repeat (20) @(posedge clk_sys);
		br(16'h0004);
	endtask
	task automatic tally_and_finish();
		$display("checks=%0d error_cnt=%0d", checks, error_cnt);
		if (error_cnt == 0 && checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	initial begin
		#(30000 * 100);
		error_cnt++;
		tally_and_finish();
	end
	initial begin
		logic [15:0] c;
		logic [15:0] prev;
		{nrst, wr, rd, ov, uv, warm, oc, ul} = '0;
		{addr, wdata, prev} = '0;
		{error_cnt, checks, frames} = '0;
		void'($urandom(94));
		repeat (3) @(posedge clk_sys);
		nrst <= 1'b1;
		@(posedge clk_sys);
		for (int i = 0; i < 8; i++) begin
			c = (i == 0) ? 16'hffff : (i == 1) ? 16'h5f80 : 16'($urandom);
			send(c);
			chk(q, stat(prev[6:1], 4'h0));
			chk({drv, 8'h00, overvoltage_lockout_enable_en, ocd_en}, {c[6:1], 8'h00, c[15], c[13]});
			prev = c;
		end
		warm <= 1'b1;
		repeat (5) @(posedge clk_sys);
		warm <= 1'b0;
		send(16'h0002);
		chk(q, stat(prev[6:1], 4'h1));
		send(16'h0003);
		chk(q, stat(6'h01, 4'h1));
		send(16'h0002);
		chk(q, stat(6'h01, 4'h0));
		ul <= 6'h01;
		repeat (5) @(posedge clk_sys);
		ul <= 6'h00;
		send(16'h8006);
		chk(q, stat(6'h01, 4'h4));
		ov <= 1'b1;
		repeat (10) @(posedge clk_sys);
		chk({10'h000, drv}, 16'h0000);
		ov <= 1'b0;
		repeat (10) @(posedge clk_sys);
		chk({10'h000, drv}, 16'h0003);
		send(16'h2006);
		chk(q, stat(6'h03, 4'h8));
		oc <= 6'h01;
		repeat (10) @(posedge clk_sys);
		oc <= 6'h00;
		repeat (10) @(posedge clk_sys);
		chk({10'h000, drv}, 16'h0002);
		send(16'h2006);
		chk(q, stat(6'h02, 4'h2));
		send(16'h2007);
		chk({10'h000, drv}, 16'h0003);
		br(16'h0010);
		chk(q, 16'h0000);
		br(16'h000C);
		chk(q, 16'(frames));
		tally_and_finish();
	end
endmodule
